// ===== hdl/spdif_rx_config_userbits.sv
/*
  Receiver configuration, converter gating, channel-status event and user-bit buffer.
  Assumes a stream decoder that presents one frame per frame_stb, synchronous to clk_sys.
*/
`timescale 1ns/1ps
module spdif_rx_config_userbits (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Register port
  input wire logic [6:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Received stream
  input wire logic frame_stb,
  input wire rx_cfg_pkg::frame_s frame_in,
  input wire logic tape_category,
  input wire logic start_id_change,
  // Reference clocks: 0 playback, 1 aux in, 2 record, 3 aux out
  input wire logic preamble_lrclk,
  input wire logic [3:0] port_lrclk,
  output logic pll_ref_clk,
  output logic pll_ref_from_port,
  output logic [1:0] pll_ref_port_select,
  // Audio out and converter feed
  output rx_cfg_pkg::stereo_s audio_out,
  output logic audio_out_valid,
  output rx_cfg_pkg::stereo_s converter_data,
  output logic converter_valid,
  // Event levels
  output logic chstat_block_irq_flag,
  output logic user_bits_irq_flag,
  output logic professional_mode_flag
);
  import rx_cfg_pkg::*;

  // ==========================================================
  // Registers
  logic [7:0] cfg2_r;
  logic [7:0] bufcfg_r;
  logic [7:0] ub_ptr_r;
  logic [7:0] rdata_r;
  logic cs_flag_r;
  logic ub_flag_r;
  logic pro_r;

  wire logic wr_cfg2 = reg_wr && (reg_addr == OFS_CONFIG_SECOND);
  wire logic wr_bufcfg = reg_wr && (reg_addr == OFS_BUFFER_CONFIG);
  wire logic wr_ptr = reg_wr && (reg_addr == OFS_UB_POINTER);
  wire logic rd_status = reg_rd && (reg_addr == OFS_STATUS);
  wire logic rd_data = reg_rd && (reg_addr == OFS_UB_DATA);

  wire logic rx_hard_mute = cfg2_r[POS_HARD_MUTE];
  wire logic block_received_flag_a_to_converter = cfg2_r[POS_BLOCK_RECEIVED_FLAG_A];
  wire logic block_invalid_to_converter = cfg2_r[POS_BLOCK_INVALID];
  wire logic tape_category_irq_option = bufcfg_r[POS_TAPE_OPT];
  wire logic user_bits_split_channels = bufcfg_r[POS_SPLIT];
  wire logic chstat_irq_mode = bufcfg_r[POS_CS_MODE];
  wire ub_mode_e user_buffer_mode = ub_mode_e'(bufcfg_r[POS_UB_MODE +: 2]);
  wire logic user_buffer_size = bufcfg_r[POS_UB_SIZE];

  // Reserved bits are masked on write so they always read as zero
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cfg2_r <= RST_CONFIG_SECOND;
      bufcfg_r <= RST_BUFFER_CONFIG;
      ub_ptr_r <= 8'h00;
    end else begin
      if (wr_cfg2) cfg2_r <= reg_wdata & MASK_CONFIG_SECOND;
      if (wr_bufcfg) bufcfg_r <= reg_wdata & MASK_BUFFER_CONFIG;
      if (wr_ptr) ub_ptr_r <= reg_wdata;
      else if (rd_data) ub_ptr_r <= ub_ptr_r + 8'h01;
    end
  end

  // ==========================================================
  // PLL reference selection
  assign pll_ref_from_port = cfg2_r[POS_REF_FROM_PORT];
  assign pll_ref_port_select = cfg2_r[POS_PORT_SEL +: 2];
  assign pll_ref_clk = pll_ref_from_port ? port_lrclk[pll_ref_port_select]
                                         : preamble_lrclk;

  // ==========================================================
  // Audio output and converter gate
  wire logic withhold = frame_in.compressed
    || (block_received_flag_a_to_converter && frame_in.received_flag_a)
    || (block_invalid_to_converter && frame_in.received_flag_b);
  stereo_s sample_in;
  assign sample_in = '{sample_l: frame_in.sample_l, sample_r: frame_in.sample_r};

  // Mute is applied to the register itself so it takes hold on the very next clock, without waiting for a frame
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      audio_out <= '0;
      audio_out_valid <= 1'b0;
      converter_data <= '0;
      converter_valid <= 1'b0;
    end else begin
      audio_out_valid <= frame_stb;
      converter_valid <= frame_stb && !withhold;
      if (rx_hard_mute) audio_out <= '0;
      else if (frame_stb) audio_out <= sample_in;
      if (frame_stb && !withhold) converter_data <= sample_in;
    end
  end

  // ==========================================================
  // Channel-status block tracking
  logic [7:0] cs_cnt_r;
  logic [CS_CMP_BITS-1:0] cs_cur_r;
  logic [CS_CMP_BITS-1:0] cs_prev_r;
  logic [CS_CMP_BITS-1:0] cs_cur_nxt;

  wire logic cs_first = frame_in.block_start;
  wire logic [7:0] cs_idx = cs_first ? 8'h00 : cs_cnt_r;
  wire logic cs_last = frame_stb && (cs_idx == 8'(CS_BLOCK_FRAMES - 1));
  always_comb begin
    cs_cur_nxt = cs_cur_r;
    if (cs_idx < 8'(CS_CMP_BITS)) cs_cur_nxt[cs_idx[5:0]] = frame_in.chstat;
  end
  wire logic cs_changed = cs_cur_nxt != cs_prev_r;
  wire logic cs_event = cs_last && (chstat_irq_mode ? cs_changed : 1'b1);

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cs_cnt_r <= 8'h00;
      cs_cur_r <= '0;
      cs_prev_r <= '0;
      pro_r <= 1'b0;
    end else if (frame_stb) begin
      cs_cnt_r <= cs_last ? 8'h00 : cs_idx + 8'h01;
      cs_cur_r <= cs_cur_nxt;
      if (cs_idx == 8'h00) pro_r <= frame_in.chstat;
      if (cs_last) cs_prev_r <= cs_cur_nxt;
    end
  end
  assign professional_mode_flag = pro_r;

  // ==========================================================
  // User-bit buffer: two buffers of 96 bytes, a byte pair written every 8 frames
  logic [7:0] ub_mem [0:2*UB_BYTES_PER_BUF-1];
  logic [8:0] ub_fcnt_r;
  logic [15:0] ub_asm_a_r;
  logic ub_buf_r;
  logic ub_iu_r;
  logic id_chg_r;

  wire logic ub_enable = (user_buffer_mode == UB_DOUBLE) || (user_buffer_mode == UB_FORMAT);
  wire logic ub_consumer_fmt = (user_buffer_mode == UB_FORMAT) && !pro_r;
  // Professional formatting is tied to the 192-frame status block, so it uses the small size
  wire logic ub_large = (user_buffer_mode == UB_DOUBLE) && user_buffer_size;
  wire logic [8:0] ub_frames = ub_large ? 9'(UB_FRAMES_LARGE) : 9'(UB_FRAMES_SMALL);
  // A 768-bit buffer spans two status blocks, so the Z in its middle must not restart it
  wire logic ub_mid_z = ub_large && (ub_fcnt_r == 9'(UB_FRAMES_SMALL));
  wire logic [8:0] ub_idx = (frame_in.block_start && !ub_mid_z) ? 9'h000 : ub_fcnt_r;
  // Consumer formatting drops the zero padding that sits between information units
  wire logic ub_skip = ub_consumer_fmt && !ub_iu_r && !frame_in.user_a && !frame_in.user_b;
  wire logic ub_take = frame_stb && ub_enable && !ub_skip;
  wire logic [15:0] ub_asm_nxt = {ub_asm_a_r[13:0], frame_in.user_a, frame_in.user_b};
  wire logic ub_pair = ub_take && (ub_idx[2:0] == 3'h7);
  wire logic ub_full = ub_take && (ub_idx == ub_frames - 9'h001);

  // Split mode keeps channel A bits in the lower half and B in the upper half
  function automatic logic [7:0] pick_bits(input logic [15:0] v, input logic odd);
    logic [7:0] r;
    r = 8'h00;
    for (int i = 0; i < 8; i++) r[i] = v[2*i + (odd ? 0 : 1)];
    return r;
  endfunction : pick_bits

  wire logic [7:0] ub_base = ub_buf_r ? 8'(UB_BYTES_PER_BUF) : 8'h00;
  wire logic [7:0] ub_half = ub_large ? 8'(UB_FRAMES_LARGE / 8) : 8'(UB_FRAMES_SMALL / 8);
  wire logic [7:0] ub_k = {2'b00, ub_idx[8:3]};
  wire logic [7:0] ub_addr0 = user_bits_split_channels ? ub_base + ub_k
                                                       : ub_base + {ub_k[6:0], 1'b0};
  wire logic [7:0] ub_addr1 = user_bits_split_channels ? ub_base + ub_half + ub_k
                                                       : ub_base + {ub_k[6:0], 1'b1};
  wire logic [7:0] ub_byte0 = user_bits_split_channels ? pick_bits(ub_asm_nxt, 1'b0)
                                                       : ub_asm_nxt[15:8];
  wire logic [7:0] ub_byte1 = user_bits_split_channels ? pick_bits(ub_asm_nxt, 1'b1)
                                                       : ub_asm_nxt[7:0];

  always_ff @(posedge clk_sys) begin
    if (ub_pair) begin
      ub_mem[ub_addr0] <= ub_byte0;
      ub_mem[ub_addr1] <= ub_byte1;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ub_fcnt_r <= 9'h000;
      ub_asm_a_r <= 16'h0000;
      ub_buf_r <= 1'b0;
      ub_iu_r <= 1'b0;
    end else if (ub_take) begin
      ub_asm_a_r <= ub_asm_nxt;
      ub_fcnt_r <= ub_full ? 9'h000 : ub_idx + 9'h001;
      ub_iu_r <= !ub_pair;
      if (ub_full) ub_buf_r <= !ub_buf_r;
    end else if (!ub_enable) begin
      ub_fcnt_r <= 9'h000;
      ub_iu_r <= 1'b0;
    end
  end

  // Tape category: the event needs a start-id change since the last buffer
  wire logic ub_gate = !(tape_category_irq_option && tape_category) || id_chg_r || start_id_change;
  wire logic ub_event = ub_full && ub_gate;

  // ==========================================================
  // Sticky flags, cleared by a status read; a new event wins over the clear
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cs_flag_r <= 1'b0;
      ub_flag_r <= 1'b0;
      id_chg_r <= 1'b0;
    end else begin
      cs_flag_r <= cs_event || (cs_flag_r && !rd_status);
      ub_flag_r <= ub_event || (ub_flag_r && !rd_status);
      id_chg_r <= (id_chg_r || start_id_change) && !ub_full;
    end
  end
  assign chstat_block_irq_flag = cs_flag_r;
  assign user_bits_irq_flag = ub_flag_r;

  // ==========================================================
  // Read path, data valid in the cycle after the strobe; unmapped reads return zero
  logic [7:0] status_word;
  always_comb begin
    status_word = 8'h00;
    status_word[POS_ST_CS_FLAG] = cs_flag_r;
    status_word[POS_ST_UB_FLAG] = ub_flag_r;
    status_word[POS_ST_UB_BUF] = ub_buf_r;
    status_word[POS_ST_PRO] = pro_r;
  end
  wire logic ptr_ok = ub_ptr_r < 8'(2 * UB_BYTES_PER_BUF);
  wire logic [7:0] rd_mux =
    (reg_addr == OFS_CONFIG_SECOND) ? cfg2_r :
    (reg_addr == OFS_BUFFER_CONFIG) ? bufcfg_r :
    (reg_addr == OFS_STATUS) ? status_word :
    (reg_addr == OFS_UB_POINTER) ? ub_ptr_r :
    ((reg_addr == OFS_UB_DATA) && ptr_ok) ? ub_mem[ub_ptr_r] : 8'h00;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) rdata_r <= 8'h00;
    else if (reg_rd) rdata_r <= rd_mux;
    else rdata_r <= 8'h00;
  end
  assign reg_rdata = rdata_r;
endmodule : spdif_rx_config_userbits

// ===== hdl/rx_cfg_pkg.sv
/*
  Constants, field layouts and carriers for the receiver control and user-bit block.
  Assumes a single 125 MHz system clock and a byte-wide register port.
*/
// What this block does
// - While the hard-mute bit is set the receiver audio output is forced to silence at once, otherwise it passes.
// - The reference bit picks the preamble frame clock at 0 and a serial-port left/right clock at 1.
// - The two-bit port selector picks playback 00, auxiliary input 01, record 10 or auxiliary output 11.
// - With the non-audio block bit set, samples flagged non-audio are withheld from the rate converter.
// - Samples carrying compressed payload are always withheld from the rate converter.
// - With the received_flag_b block bit set, samples flagged invalid are withheld from the rate converter.
// - With the tape option set and tape category seen, the user-bit event fires only after a start-id change.
// - User bits of both channels are stored interleaved at 0 and in separate halves at 1.
// - In channel-status mode 0 the block flag is set after every complete 192-frame block.
// - In channel-status mode 1 the block flag is set only when the first five bytes differ from the last block.
// - User-buffer mode 00 ignores user bits, mode 01 double-buffers, filling the second when the first is full.
// - User-buffer mode 10 formats user bits by the professional flag, and 11 is reserved.
// - In double-buffer mode each buffer holds 384 bits at size 0 and 768 bits at size 1, started at Z.
package rx_cfg_pkg;
  // ==========================================================
  // Register map
  localparam logic [6:0] OFS_CONFIG_SECOND = 7'h0A;
  localparam logic [6:0] OFS_BUFFER_CONFIG = 7'h0B;
  localparam logic [6:0] OFS_STATUS = 7'h20;
  localparam logic [6:0] OFS_UB_POINTER = 7'h21;
  localparam logic [6:0] OFS_UB_DATA = 7'h22;
  localparam logic [7:0] RST_CONFIG_SECOND = 8'h00;
  localparam logic [7:0] RST_BUFFER_CONFIG = 8'h00;
  localparam logic [7:0] MASK_CONFIG_SECOND = 8'hF3;
  localparam logic [7:0] MASK_BUFFER_CONFIG = 8'h3F;

  // ==========================================================
  // Field positions
  localparam int POS_HARD_MUTE = 7;
  localparam int POS_REF_FROM_PORT = 6;
  localparam int POS_PORT_SEL = 4;
  localparam int POS_BLOCK_RECEIVED_FLAG_A = 1;
  localparam int POS_BLOCK_INVALID = 0;
  localparam int POS_TAPE_OPT = 5;
  localparam int POS_SPLIT = 4;
  localparam int POS_CS_MODE = 3;
  localparam int POS_UB_MODE = 1;
  localparam int POS_UB_SIZE = 0;
  localparam int POS_ST_CS_FLAG = 0;
  localparam int POS_ST_UB_FLAG = 1;
  localparam int POS_ST_UB_BUF = 2;
  localparam int POS_ST_PRO = 3;

  // ==========================================================
  // Counts
  localparam int CS_BLOCK_FRAMES = 192;
  localparam int CS_CMP_BITS = 40;
  localparam int UB_BYTES_PER_BUF = 96;
  localparam int UB_FRAMES_SMALL = 192;
  localparam int UB_FRAMES_LARGE = 384;

  typedef enum logic [1:0] {UB_IGNORE, UB_DOUBLE, UB_FORMAT, UB_RESERVED} ub_mode_e;

  // One received frame from the stream decoder
  typedef struct packed {
    logic [23:0] sample_l;
    logic [23:0] sample_r;
    logic user_a;
    logic user_b;
    logic chstat;
    logic block_start;
    logic received_flag_a;
    logic received_flag_b;
    logic compressed;
  } frame_s;

  typedef struct packed {
    logic [23:0] sample_l;
    logic [23:0] sample_r;
  } stereo_s;
endpackage : rx_cfg_pkg

// ===== testbench/rx_cfg_checker.sv
/* Assertions on the ports of the receiver configuration block.
   Assumes the configuration changes only through register writes. */
`timescale 1ns/1ps
module rx_cfg_checker
  import rx_cfg_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Register port
  input wire logic [6:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // Stream and outputs
  input wire logic frame_stb,
  input wire rx_cfg_pkg::frame_s frame_in,
  input wire logic preamble_lrclk,
  input wire logic [3:0] port_lrclk,
  input wire logic pll_ref_clk,
  input wire logic pll_ref_from_port,
  input wire logic [1:0] pll_ref_port_select,
  input wire rx_cfg_pkg::stereo_s audio_out,
  input wire logic audio_out_valid,
  input wire rx_cfg_pkg::stereo_s converter_data,
  input wire logic converter_valid
);
  // ==========================================================
  // Shadow of the configuration register
  logic [7:0] cfg_r;
  logic [7:0] cfg_nxt;
  logic pass_w;
  assign cfg_nxt = (reg_wr && reg_addr == OFS_CONFIG_SECOND) ?
                   (reg_wdata & MASK_CONFIG_SECOND) : cfg_r;
  assign pass_w = !frame_in.compressed &&
                  !(frame_in.received_flag_a && cfg_r[POS_BLOCK_RECEIVED_FLAG_A]) &&
                  !(frame_in.received_flag_b && cfg_r[POS_BLOCK_INVALID]);
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) cfg_r <= RST_CONFIG_SECOND;
    else cfg_r <= cfg_nxt;
  end

  // ==========================================================
  // Properties
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  sequence muted_out;
    audio_out_valid && audio_out == '0;
  endsequence
  chk_mute_silent: assert property (frame_stb && cfg_r[POS_HARD_MUTE] |=> muted_out)
    else $error("audio not silent while muted");
  chk_unmuted_pass: assert property (frame_stb && !cfg_r[POS_HARD_MUTE] ##1
    !cfg_r[POS_HARD_MUTE] |-> audio_out == $past({frame_in.sample_l, frame_in.sample_r}))
    else $error("unmuted audio differs from frame");
  chk_ref_fields: assert property (pll_ref_from_port == cfg_r[POS_REF_FROM_PORT] &&
    pll_ref_port_select == cfg_r[POS_PORT_SEL+:2])
    else $error("reference fields differ from register");
  chk_ref_mux: assert property (pll_ref_clk ==
    (pll_ref_from_port ? port_lrclk[pll_ref_port_select] : preamble_lrclk))
    else $error("wrong reference clock selected");
  chk_compressed_held: assert property (frame_stb && frame_in.compressed |=> !converter_valid)
    else $error("compressed frame reached converter");
  chk_received_flag_a_held: assert property (frame_stb && frame_in.received_flag_a &&
    cfg_r[POS_BLOCK_RECEIVED_FLAG_A] |=> !converter_valid)
    else $error("non-audio frame reached converter");
  chk_invalid_held: assert property (frame_stb && frame_in.received_flag_b &&
    cfg_r[POS_BLOCK_INVALID] |=> !converter_valid)
    else $error("invalid frame reached converter");
  chk_forward_data: assert property (frame_stb && pass_w |=> converter_valid &&
    converter_data == $past({frame_in.sample_l, frame_in.sample_r}))
    else $error("forwarded frame missing or wrong");
  chk_cfg_readback: assert property (reg_rd && reg_addr == OFS_CONFIG_SECOND |=>
    reg_rdata == $past(cfg_r))
    else $error("configuration readback wrong");
endmodule : rx_cfg_checker

bind spdif_rx_config_userbits rx_cfg_checker chk_u (
  .clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .frame_stb(frame_stb),
  .frame_in(frame_in), .preamble_lrclk(preamble_lrclk), .port_lrclk(port_lrclk),
  .pll_ref_clk(pll_ref_clk), .pll_ref_from_port(pll_ref_from_port),
  .pll_ref_port_select(pll_ref_port_select), .audio_out(audio_out),
  .audio_out_valid(audio_out_valid), .converter_data(converter_data),
  .converter_valid(converter_valid)
);

// ===== testbench/stream_src_model.sv
/* Behavioural source of received frames and of the reference clocks.
   Assumes the bench calls its tasks from one process at a time. */
`timescale 1ns/1ps
module stream_src_model
  import rx_cfg_pkg::*;
(
  // Clock
  input wire logic clk_sys,
  // Stream towards the receiver
  output logic frame_stb,
  output rx_cfg_pkg::frame_s frame_in,
  // Reference clocks, each at its own rate so the selection is visible
  output logic preamble_lrclk,
  output logic [3:0] port_lrclk
);
  stereo_s last;
  logic [7:0] seq_r = 8'h00;
  logic [7:0] div_r = 8'h00;
  initial begin
    frame_stb = 1'b0;
    frame_in = '0;
  end
  always @(posedge clk_sys) div_r <= div_r + 8'h01;
  assign preamble_lrclk = div_r[0];
  assign port_lrclk = div_r[4:1];

  // ==========================================================
  // One frame, then a gap; the bus shows garbage between frames
  task automatic send(input logic a, b, c, z, cs, ua);
    @(posedge clk_sys);
    seq_r = seq_r + 8'h01;
    last = {16'hA500, seq_r, 16'h5A00, ~seq_r};
    frame_stb <= 1'b1;
    frame_in <= {last, ua, 1'b0, cs, z, a, b, c};
    @(posedge clk_sys);
    frame_stb <= 1'b0;
    frame_in <= ~frame_in;
  endtask : send

  // A whole channel-status block, Z preamble on frame 0
  task automatic block(input logic [39:0] pat);
    for (int i = 0; i < CS_BLOCK_FRAMES; i++) begin
      send(1'b0, 1'b0, 1'b0, i == 0, (i < CS_CMP_BITS) ? pat[i] : 1'b0, 1'b1);
    end
  endtask : block
endmodule : stream_src_model

// ===== testbench/tb_top.sv
/* Self-checking bench for the receiver configuration block.
   Assumes the checker is bound through its own file. */
`timescale 1ns/1ps
module tb_top;
  import rx_cfg_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [6:0] reg_addr = 7'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic frame_stb;
  frame_s frame_in;
  logic preamble_lrclk;
  logic [3:0] port_lrclk;
  logic pll_ref_clk;
  logic pll_ref_from_port;
  logic [1:0] pll_ref_port_select;
  stereo_s audio_out;
  stereo_s converter_data;
  logic audio_out_valid;
  logic converter_valid;
  logic cs_flag;
  logic ub_flag;
  logic pro_flag;
  logic fwd;
  logic tape_cat = 1'b0;
  logic id_chg = 1'b0;
  int n_mismatch = 0;
  int n_tests = 0;

  always #4 clk_sys = ~clk_sys;

  stream_src_model src_u (.clk_sys(clk_sys), .frame_stb(frame_stb), .frame_in(frame_in),
    .preamble_lrclk(preamble_lrclk), .port_lrclk(port_lrclk));
  spdif_rx_config_userbits dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .frame_stb(frame_stb), .frame_in(frame_in), .tape_category(tape_cat),
    .start_id_change(id_chg), .preamble_lrclk(preamble_lrclk), .port_lrclk(port_lrclk),
    .pll_ref_clk(pll_ref_clk), .pll_ref_from_port(pll_ref_from_port),
    .pll_ref_port_select(pll_ref_port_select), .audio_out(audio_out),
    .audio_out_valid(audio_out_valid), .converter_data(converter_data),
    .converter_valid(converter_valid), .chstat_block_irq_flag(cs_flag),
    .user_bits_irq_flag(ub_flag), .professional_mode_flag(pro_flag));

  // ==========================================================
  // Register port and comparison
  task automatic cmp(input logic [47:0] exp, input logic [47:0] got, input string what);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr
  // Read data stand only in the cycle after the strobe
  task automatic rdm(input logic [6:0] a, input logic [7:0] m, input logic [7:0] e,
                     input string what);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    cmp(e, reg_rdata & m, what);
  endtask : rdm
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : stop_test

  // ==========================================================
  // Tests
  initial begin
    repeat (16) @(posedge clk_sys);
    rst_n <= 1'b1;
    rdm(OFS_CONFIG_SECOND, 8'hFF, RST_CONFIG_SECOND, "cfg reset");
    rdm(OFS_BUFFER_CONFIG, 8'hFF, RST_BUFFER_CONFIG, "bcfg reset");
    wr(OFS_CONFIG_SECOND, MASK_CONFIG_SECOND);
    rdm(OFS_CONFIG_SECOND, 8'hFF, MASK_CONFIG_SECOND, "cfg readback");
    wr(OFS_BUFFER_CONFIG, 8'h3B);
    rdm(OFS_BUFFER_CONFIG, 8'hFF, 8'h3B, "bcfg readback");
    rdm(7'h7F, 8'hFF, 8'h00, "unmapped");
    $display("test registers done");
    for (int s = 0; s < 8; s++) begin
      wr(OFS_CONFIG_SECOND, {1'b0, s[2], s[1:0], 4'h0});
      @(negedge clk_sys);
      cmp({s[2], s[1:0]}, {pll_ref_from_port, pll_ref_port_select}, "ref fields");
      cmp(s[2] ? port_lrclk[s[1:0]] : preamble_lrclk, pll_ref_clk, "ref clock");
    end
    $display("test reference done");
    // Every mix of block bits and frame flags, compressed included
    for (int k = 0; k < 32; k++) begin
      wr(OFS_CONFIG_SECOND, {6'h00, k[4:3]});
      src_u.send(k[2], k[1], k[0], 1'b0, 1'b0, 1'b0);
      #1;
      fwd = !k[0] && !(k[2] && k[4]) && !(k[1] && k[3]);
      cmp(fwd, converter_valid, "converter valid");
      if (fwd) cmp(src_u.last, converter_data, "converter data");
    end
    $display("test gating done");
    wr(OFS_CONFIG_SECOND, 8'h80);
    src_u.send(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
    #1;
    cmp(48'h0, audio_out, "muted audio");
    wr(OFS_CONFIG_SECOND, 8'h00);
    src_u.send(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
    #1;
    cmp(src_u.last, audio_out, "unmuted audio");
    $display("test mute done");
    // Status read clears both event flags before the block tests
    rdm(OFS_STATUS, 8'hFF, 8'h00, "status flush");
    wr(OFS_BUFFER_CONFIG, 8'h00);
    src_u.block(40'h0);
    rdm(OFS_STATUS, 8'h0B, 8'h01, "status mode0 ignore");
    wr(OFS_BUFFER_CONFIG, 8'h0A);
    src_u.block(40'h0);
    rdm(OFS_STATUS, 8'h0B, 8'h02, "status same block");
    wr(OFS_UB_POINTER, 8'h00);
    rdm(OFS_UB_DATA, 8'hFF, 8'hAA, "user byte");
    src_u.block(40'h9);
    rdm(OFS_STATUS, 8'h09, 8'h09, "status changed block");
    cmp(1'b1, pro_flag, "pro flag");
    $display("test blocks done");
    // Tape category: the user event waits for a start-id change
    wr(OFS_BUFFER_CONFIG, 8'h22);
    tape_cat <= 1'b1;
    src_u.block(40'h0);
    #1;
    cmp(1'b0, ub_flag, "tape without id change");
    cmp(1'b1, cs_flag, "cs flag pin");
    @(posedge clk_sys);
    id_chg <= 1'b1;
    @(posedge clk_sys);
    id_chg <= 1'b0;
    src_u.block(40'h0);
    #1;
    cmp(1'b1, ub_flag, "tape with id change");
    // Split storage: channel A bytes first, channel B bytes a half buffer later
    wr(OFS_BUFFER_CONFIG, 8'h12);
    src_u.block(40'h0);
    wr(OFS_UB_POINTER, 8'h00);
    rdm(OFS_UB_DATA, 8'hFF, 8'hFF, "split channel a");
    wr(OFS_UB_POINTER, 8'h18);
    rdm(OFS_UB_DATA, 8'hFF, 8'h00, "split channel b");
    rdm(OFS_STATUS, 8'hFF, 8'h07, "status split");
    wr(OFS_BUFFER_CONFIG, 8'h04);
    src_u.block(40'h1);
    rdm(OFS_STATUS, 8'hFF, 8'h0B, "status format");
    // A 768-bit buffer needs two status blocks before it is full
    wr(OFS_BUFFER_CONFIG, 8'h03);
    src_u.block(40'h0);
    #1;
    cmp(1'b0, ub_flag, "large half way");
    src_u.block(40'h0);
    #1;
    cmp(1'b1, ub_flag, "large full");
    $display("test user bits done");
    stop_test();
  end

  initial begin
    #(8 * 10000);
    n_mismatch++;
    stop_test();
  end
endmodule : tb_top
